// >>> hw/swc_sleep_ctrl.sv
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// RULE_01 - Mode 5: low request wakes, flow low
// RULE_02 - Mode 5: awake while request low (drain state ignores the request and can still enter sleep)
// RULE_03 - Mode 5: short pulse gives full wake
// RULE_04 - Activity restarts wake timer before sleeping
// RULE_05 - Mode 7: synced, never sleeps, answers joiners
// RULE_06 - Mode 7: data only in network awake
// RULE_07 - No synchronous sleep at baud code 0
// RULE_08 - Mode 8: sleep, wake together, ignore input
// RULE_09 - Mode 8: local timing until synchronized
// RULE_10 - Sleep indicator high awake, low asleep
// RULE_11 - Flow output high asleep, low ready
// RULE_12 - Unsynced sleeper polls, sleeps, repeats
// RULE_13 - Pin mode: request high sleeps, low wakes
// RULE_14 - Mode 5: falling edge wakes, rising ignored
// RULE_15 - Pin config 0: alternate select is request
// RULE_16 - Commissioning input wakes from pin sleep
// RULE_17 - Command mode, config, serial output block sleep
// RULE_18 - Pin wake lasts one serial character
// RULE_19 - Minimum wake: wake-time or 30 ms poll
// RULE_20 - Received data extends wake by wake-time
// RULE_21 - Pending transmit, pin request deassert block sleep
// RULE_22 - Modes 4,5: receive starts time-until-sleep
// RULE_23 - Cyclic wake each period, sends poll
// RULE_24 - Pin sleep finishes activity, idles first
// RULE_25 - Inputs synchronized before detection
module swc_sleep_ctrl #(
   parameter int UNIT_CYCLES = swc_pkg::UNIT_CYC,
   parameter int CHAR_CYCLES = swc_pkg::CHAR_CYC
) (
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   sleepRequestIn,
   input  wire logic                   altSelectIn,
   input  wire logic                   commissioningIn,
   input  wire swc_pkg::swc_activity_s act,
   input  wire swc_pkg::swc_sync_s     sync,
   output logic                        flowOut,
   output logic                        sleepIndicator,
   output logic                        awake,
   output logic                        pollReq,
   output logic                        syncReq,
   output logic                        syncAnswerEn,
   output logic                        dataTxAllow,
   output logic                        inputAccept,
   output logic                        commButton
);
   import swc_pkg::*;

   logic [31:0] ctrlReg, wakeReg, sleepReg;
   logic [2:0]  s1, s2, s3;
   swc_state_e  state;
   logic [31:0] unitCnt;
   logic [15:0] msLeft, slpLeft;
   logic [31:0] charCnt;
   logic        synced, pinWoke;

   // Bus slave
   logic        awHeld, wHeld, arBusy;
   logic [7:0]  awAddr;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   wire         doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire         wrOk    = awAddr == OFF_CTRL || awAddr == OFF_WAKE || awAddr == OFF_SLEEP;
   wire [31:0]  wMask   = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
   wire [3:0]   mode    = ctrlReg[CTRL_MODE_LSB +: 4];
   wire [3:0]   baud    = ctrlReg[CTRL_BAUD_LSB +: 4];

   assign s_axi_awready = !awHeld;
   assign s_axi_wready  = !wHeld;
   assign s_axi_arready = !arBusy;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         ctrlReg <= CTRL_RESET;
         wakeReg <= WAKE_RESET;
         sleepReg <= SLEEP_RESET;
      end else begin
         if (s_axi_awvalid && !awHeld) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeld) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
            if (awAddr == OFF_CTRL)
               ctrlReg <= (ctrlReg & ~wMask) | (wData & wMask);
            if (awAddr == OFF_WAKE)
               wakeReg <= (wakeReg & ~wMask) | (wData & wMask);
            if (awAddr == OFF_SLEEP)
               sleepReg <= (sleepReg & ~wMask) | (wData & wMask);
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire [31:0] statusWord = {26'h0, pinWoke, synced, awake, state == SWC_DRAIN, state};
   logic [31:0] rdMux;
   logic        rdOk;
   always_comb begin
      rdOk = 1'b1;
      case (s_axi_araddr)
         OFF_CTRL:     rdMux = ctrlReg;
         OFF_WAKE:     rdMux = wakeReg;
         OFF_SLEEP:    rdMux = sleepReg;
         OFF_STATUS:   rdMux = statusWord;
         OFF_NET_WAKE: rdMux = {16'h0, synced ? sync.netWake : wakeReg[15:0]};
         OFF_NET_SLP:  rdMux = {16'h0, synced ? sync.netSleep : sleepReg[15:0]};
         default: begin
            rdMux = 32'h0000_0000;
            rdOk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         arBusy <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && !arBusy) begin
         arBusy <= 1'b1;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         arBusy <= 1'b0;
         s_axi_rvalid <= 1'b0;
      end
   end

   // Input synchronizers, idle high
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= 3'h7;
         s2 <= 3'h7;
         s3 <= 3'h7;
      end else begin
         s1 <= {commissioningIn, altSelectIn, sleepRequestIn}; // [RULE_25]
         s2 <= s1;
         s3 <= s2;
      end
   end

   wire altSel  = ctrlReg[CTRL_ALTSEL_BIT] && !ctrlReg[CTRL_REQPIN_BIT];
   wire reqCur  = altSel ? s2[1] : s2[0];               // [RULE_15]
   wire reqPrev = altSel ? s3[1] : s3[0];
   wire reqLow  = !reqCur;
   wire reqFall = reqPrev && !reqCur;                   // [RULE_14]
   wire commEn  = ctrlReg[CTRL_COMM_BIT];
   wire commLow = commEn && !s2[2];                     // [RULE_16]
   assign commButton = commEn && s3[2] && !s2[2];

   wire isPin    = mode == MODE_PIN;
   wire isCyc    = mode == MODE_CYC || mode == MODE_CYC_PIN;
   wire syncOk   = baud != 4'h0;                        // [RULE_07]
   wire isSupp   = mode == MODE_SYNC_SUP && syncOk;
   wire isSyncC  = mode == MODE_SYNC_CYC && syncOk;
   wire neverSlp = !(isPin || isCyc || isSyncC);
   wire fullSt   = ctrlReg[CTRL_FULLST_BIT];

   // Local timing until synced, then network timing
   wire [15:0] wakeMs  = (synced && isSyncC) ? sync.netWake : wakeReg[15:0];  // [RULE_09]
   wire [15:0] sleepMs = (synced && isSyncC) ? sync.netSleep : sleepReg[15:0];

   wire blockCmd = act.cmdMode || act.cfgBusy
                   || (act.serOutPending && !act.rtsHold);           // [RULE_17]
   wire blockTx  = act.txPending;                                    // [RULE_21]
   wire rxData   = act.serRx || act.rfRx;
   wire pinHold  = isPin && (reqLow || commLow);                     // [RULE_13] [RULE_21]
   wire cycPinLow = mode == MODE_CYC_PIN && reqLow;                  // [RULE_02]
   wire timersDone = msLeft == 16'h0 && charCnt == 32'h0;
   wire mayDrain = !pinHold && !cycPinLow && !blockCmd && !blockTx && timersDone;
   wire unitTick = unitCnt == 32'(UNIT_CYCLES - 1);

   wire pinWake  = isPin && (reqLow || commLow);                     // [RULE_13] [RULE_16]
   wire cycPinWk = mode == MODE_CYC_PIN && reqFall;                  // [RULE_01] [RULE_14]
   wire periodUp = (isCyc || isSyncC) && slpLeft == 16'h0 && unitTick; // [RULE_23] [RULE_08]
   wire slpWake  = !isSyncC || !synced || sync.netAwake;
   wire [15:0] minWake = fullSt || pinWoke ? wakeMs : 16'(POLL_MS);  // [RULE_19]

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         unitCnt <= 32'h0;
      else
         unitCnt <= unitTick ? 32'h0 : unitCnt + 32'h1;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= SWC_AWAKE;
         msLeft <= 16'h0;
         slpLeft <= 16'h0;
         charCnt <= 32'h0;
         pinWoke <= 1'b0;
         synced <= 1'b0;
         pollReq <= 1'b0;
         syncReq <= 1'b0;
      end else begin
         pollReq <= 1'b0;
         syncReq <= 1'b0;
         if (!(isSupp || isSyncC))
            synced <= 1'b0;
         else if (sync.syncRx && state != SWC_SLEEP)
            synced <= 1'b1;                                          // [RULE_12]
         if (unitTick && msLeft != 16'h0)
            msLeft <= msLeft - 16'h1;
         if (unitTick && slpLeft != 16'h0)
            slpLeft <= slpLeft - 16'h1;
         if (charCnt != 32'h0)
            charCnt <= charCnt - 32'h1;
         case (state)
            SWC_SLEEP: begin
               if (neverSlp) begin
                  state <= SWC_AWAKE;                                // [RULE_05]
               end else if (pinWake) begin
                  state <= SWC_AWAKE;
                  charCnt <= 32'(CHAR_CYCLES);                       // [RULE_18]
               end else if (cycPinWk) begin
                  state <= SWC_AWAKE;
                  pinWoke <= 1'b1;
                  msLeft <= wakeMs;                                  // [RULE_03]
               end else if (periodUp && slpWake) begin
                  state <= SWC_AWAKE;
                  msLeft <= fullSt ? wakeMs : 16'(POLL_MS);          // [RULE_19]
                  pollReq <= isCyc && !ctrlReg[CTRL_POLLER_BIT] ? 1'b1 : isCyc; // [RULE_23]
                  syncReq <= isSyncC && !synced;                     // [RULE_12]
               end
            end
            SWC_AWAKE: begin
               if (isSyncC && synced && !sync.netAwake) begin
                  state <= SWC_DRAIN;                                // [RULE_08]
               end else if (isSyncC && !synced && msLeft == 16'h0 && !blockCmd) begin
                  state <= SWC_DRAIN;
               end else if (rxData && (isCyc || isSyncC)) begin
                  msLeft <= wakeMs;                                  // [RULE_04] [RULE_20] [RULE_22]
               end else if (cycPinWk) begin
                  msLeft <= wakeMs;                                  // [RULE_03]
                  pinWoke <= 1'b1;
               end else if (!neverSlp && mayDrain) begin
                  state <= SWC_DRAIN;
               end
               if (isCyc && msLeft == 16'h0 && !pinWoke && minWake == 16'h0)
                  pinWoke <= 1'b0;
            end
            SWC_DRAIN: begin
               if (neverSlp || pinWake && isPin) begin
                  state <= SWC_AWAKE;
               end else if (!act.rxBusy && !blockTx && !blockCmd) begin
                  state <= SWC_SLEEP;                                // [RULE_24]
                  pinWoke <= 1'b0;
                  slpLeft <= sleepMs;
               end
            end
            default: state <= SWC_AWAKE;
         endcase
      end
   end

   assign awake        = state != SWC_SLEEP;
   assign inputAccept  = awake;                                      // [RULE_08]
   assign syncAnswerEn = isSupp || (isSyncC && synced && awake);     // [RULE_05]
   assign dataTxAllow  = isSupp ? (synced && sync.netAwake) : awake; // [RULE_06]

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         flowOut <= 1'b1;
         sleepIndicator <= 1'b0;
      end else begin
         flowOut <= ctrlReg[CTRL_FLOW_BIT] ? !(state == SWC_AWAKE) : 1'b0; // [RULE_11] [RULE_01]
         sleepIndicator <= ctrlReg[CTRL_IND_BIT] ? awake : 1'b0;            // [RULE_10]
      end
   end

   a_pin_sleep_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
      (isPin && pinHold && state == SWC_AWAKE) |=> state == SWC_AWAKE) // [RULE_13]
      else $error("pin sleep entered while request low");
   a_fall_wakes: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == SWC_SLEEP && mode == MODE_CYC_PIN && reqFall) |=> awake) // [RULE_14]
      else $error("falling edge did not wake");
   a_block_cmd: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == SWC_DRAIN && blockCmd) |=> state != SWC_SLEEP) // [RULE_17]
      else $error("slept during command activity");
   a_tx_block: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == SWC_DRAIN && act.txPending) |=> state != SWC_SLEEP) // [RULE_21]
      else $error("slept with transmit pending");
   a_support_awake: assert property (@(posedge core_clk) disable iff (!arst_n)
      isSupp |-> ##1 state != SWC_SLEEP ##1 state != SWC_SLEEP) // [RULE_05]
      else $error("support node slept");
   a_ind_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
      ctrlReg[CTRL_IND_BIT] && $stable(ctrlReg) |=> sleepIndicator == $past(awake)) // [RULE_10]
      else $error("indicator wrong");
   a_flow_asleep: assert property (@(posedge core_clk) disable iff (!arst_n)
      (ctrlReg[CTRL_FLOW_BIT] && state == SWC_SLEEP) |=> flowOut) // [RULE_11]
      else $error("flow output low while asleep");
   a_baud_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
      (baud == 4'h0) |-> !syncAnswerEn) // [RULE_07]
      else $error("sync active at baud code 0");
   a_mode5_low: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == SWC_AWAKE && cycPinLow) |=> state == SWC_AWAKE) // [RULE_02]
      else $error("mode 5 slept with request low");
   a_rx_extend: assert property (@(posedge core_clk) disable iff (!arst_n)
      (state == SWC_AWAKE && isCyc && rxData && wakeMs != 16'h0) |=> msLeft != 16'h0) // [RULE_20]
      else $error("receive did not extend wake");

endmodule // swc_sleep_ctrl

// >>> hw/swc_pkg.sv
package swc_pkg;

   // Sleep mode codes
   localparam logic [3:0] MODE_AWAKE    = 4'h0;
   localparam logic [3:0] MODE_PIN      = 4'h1;
   localparam logic [3:0] MODE_CYC      = 4'h4;
   localparam logic [3:0] MODE_CYC_PIN  = 4'h5;
   localparam logic [3:0] MODE_SYNC_SUP = 4'h7;
   localparam logic [3:0] MODE_SYNC_CYC = 4'h8;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_WAKE     = 8'h04;
   localparam logic [7:0] OFF_SLEEP    = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0C;
   localparam logic [7:0] OFF_NET_WAKE = 8'h10;
   localparam logic [7:0] OFF_NET_SLP  = 8'h14;

   // Control register fields
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_FLOW_BIT   = 4;
   localparam int CTRL_REQPIN_BIT = 5;
   localparam int CTRL_IND_BIT    = 6;
   localparam int CTRL_COMM_BIT   = 7;
   localparam int CTRL_ALTSEL_BIT = 8;
   localparam int CTRL_FULLST_BIT = 9;
   localparam int CTRL_POLLER_BIT = 10;
   localparam int CTRL_BAUD_LSB   = 12;

   localparam logic [31:0] CTRL_RESET  = 32'h0000_10B0;
   localparam logic [31:0] WAKE_RESET  = 32'h0000_07D0;
   localparam logic [31:0] SLEEP_RESET = 32'h0000_00C8;

   // One wake/sleep unit is 1 ms
   localparam int CLK_MHZ     = 100;
   localparam int UNIT_US     = 1000;
   localparam int UNIT_CYC    = CLK_MHZ * UNIT_US;
   localparam int POLL_MS     = 30;
   localparam int CHAR_US     = 1042;
   localparam int CHAR_CYC    = (CHAR_US * CLK_MHZ);

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SWC_SLEEP = 2'b00,
      SWC_AWAKE = 2'b01,
      SWC_DRAIN = 2'b11
   } swc_state_e;

   typedef struct packed {
      logic cmdMode;
      logic cfgBusy;
      logic serOutPending;
      logic rtsHold;
      logic txPending;
      logic rxBusy;
      logic serRx;
      logic rfRx;
   } swc_activity_s;

   typedef struct packed {
      logic syncRx;
      logic [15:0] netWake;
      logic [15:0] netSleep;
      logic netAwake;
   } swc_sync_s;

endpackage

// >>> tb/swc_host_model.sv
`timescale 1ns/1ps
module swc_host_model (
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic wantSleep,
   input  wire logic wantAlt,
   input  wire logic pressBtn,
   input  wire logic flowOut,
   output logic      sleepRequestIn,
   output logic      altSelectIn,
   output logic      commissioningIn,
   output logic      hostMaySend
);
   // Pins idle high and change just after the clock edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sleepRequestIn  <= 1'b1;
         altSelectIn     <= 1'b1;
         commissioningIn <= 1'b1;
      end else begin
         sleepRequestIn  <= wantSleep;
         altSelectIn     <= wantAlt;
         commissioningIn <= !pressBtn;
      end
   end
   // Serial traffic only while the flow line is low
   assign hostMaySend = !flowOut;
endmodule // swc_host_model

// >>> tb/swc_sleep_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errCount++; \
   $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end
module swc_sleep_ctrl_tb;
   import swc_pkg::*;
   logic          core_clk, arst_n, awValid, awReady, wValid, wReady, bValid, bReady;
   logic          arValid, arReady, rValid, rReady, wantSleep, wantAlt, pressBtn;
   logic [7:0]    awAddr, arAddr;
   logic [31:0]   wData, rData, d;
   logic [3:0]    wStrb;
   logic [1:0]    bResp, rResp, r;
   logic          reqPin, altPin, commPin, hostMaySend, flowOut, sleepIndicator, awake;
   logic          pollReq, syncReq, syncAnswerEn, dataTxAllow, inputAccept, commButton;
   logic          btnSeen = 1'b0;
   int            pollCnt = 0;
   int            syncCnt = 0;
   int            errCount = 0;
   int            nTests = 0;
   int            cycles = 0;
   int            p0;
   swc_activity_s act;
   swc_sync_s     sync;

   swc_sleep_ctrl #(.UNIT_CYCLES(10), .CHAR_CYCLES(5)) dut (
      .core_clk(core_clk), .arst_n(arst_n),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .sleepRequestIn(reqPin), .altSelectIn(altPin), .commissioningIn(commPin),
      .act(act), .sync(sync), .flowOut(flowOut), .sleepIndicator(sleepIndicator),
      .awake(awake), .pollReq(pollReq), .syncReq(syncReq), .syncAnswerEn(syncAnswerEn),
      .dataTxAllow(dataTxAllow), .inputAccept(inputAccept), .commButton(commButton));

   swc_host_model host (
      .core_clk(core_clk), .arst_n(arst_n), .wantSleep(wantSleep), .wantAlt(wantAlt),
      .pressBtn(pressBtn), .flowOut(flowOut), .sleepRequestIn(reqPin),
      .altSelectIn(altPin), .commissioningIn(commPin), .hostMaySend(hostMaySend));

   always #5 core_clk = ~core_clk;

   // Pulse outputs are counted or latched so the main sequence can look at them later
   always @(posedge core_clk) begin
      cycles++;
      if (commButton === 1'b1) btnSeen <= 1'b1;
      if (pollReq === 1'b1) pollCnt++;
      if (syncReq === 1'b1) syncCnt++;
      if (cycles == 30000) begin
         errCount++;
         closeOut();
      end
   end

   task automatic closeOut;
      $display("Checks %0d, mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Ready and valid are sampled at the falling edge, where they hold the value
   // that the next rising edge takes
   task automatic axiWr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aPend, wPend, aRdy, wRdy, bv;
      @(posedge core_clk);
      awAddr <= a;
      wData <= v;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      aPend = 1'b1;
      wPend = 1'b1;
      bv = 1'b0;
      while (!bv) begin
         @(negedge core_clk);
         aRdy = awReady;
         wRdy = wReady;
         bv = bValid;
         rs = bResp;
         @(posedge core_clk);
         if (aPend && aRdy === 1'b1) begin
            awValid <= 1'b0;
            aPend = 1'b0;
         end
         if (wPend && wRdy === 1'b1) begin
            wValid <= 1'b0;
            wPend = 1'b0;
         end
      end
      bReady <= 1'b0;
   endtask

   task automatic axiRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic aRdy, rv;
      @(posedge core_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      rv = 1'b0;
      while (!rv) begin
         @(negedge core_clk);
         aRdy = arReady;
         rv = rValid;
         v = rData;
         rs = rResp;
         @(posedge core_clk);
         if (aRdy === 1'b1) arValid <= 1'b0;
      end
      rReady <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic waitAwake(input logic v, input int n);
      int i;
      i = 0;
      while (awake !== v && i < n) begin
         cyc(1);
         i++;
      end
   endtask

   task automatic pulseReq;
      @(posedge core_clk);
      wantSleep <= 1'b0;
      @(posedge core_clk);
      wantSleep <= 1'b1;
      waitAwake(1'b1, 10);
   endtask

   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      {awValid, wValid, bReady, arValid, rReady, wantAlt, pressBtn} = '0;
      {awAddr, arAddr, wData} = '0;
      wStrb = 4'hF;
      wantSleep = 1'b1;
      act = '0;
      sync = '0;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      axiRd(OFF_CTRL, d, r);
      `CHK("ctrl reset", CTRL_RESET, d)
      axiRd(OFF_WAKE, d, r);
      `CHK("wake reset", WAKE_RESET, d)
      axiRd(OFF_SLEEP, d, r);
      `CHK("sleep reset", SLEEP_RESET, d)
      axiRd(8'h20, d, r);
      `CHK("unmapped resp", RESP_SLVERR, r)
      `CHK("unmapped data", 32'h0000_0000, d)
      axiWr(OFF_STATUS, 32'h0000_0000, r);
      `CHK("status write", RESP_SLVERR, r)
      axiWr(OFF_WAKE, 32'h0000_0003, r);
      axiWr(OFF_SLEEP, 32'h0000_0014, r);
      `CHK("sleep write", RESP_OKAY, r)
      // Pin sleep with flow and indicator outputs on
      axiWr(OFF_CTRL, 32'h0000_1071, r);
      waitAwake(1'b0, 200);
      // Indicator is registered from awake, so it settles one cycle after sleep
      cyc(1);
      `CHK("pin asleep", 1'b0, awake)
      `CHK("flow asleep", 1'b1, flowOut)
      `CHK("ind asleep", 1'b0, sleepIndicator)
      @(posedge core_clk);
      wantSleep <= 1'b0;
      waitAwake(1'b1, 10);
      cyc(2);
      `CHK("pin awake", 1'b1, awake)
      `CHK("flow awake", 1'b0, flowOut)
      `CHK("ind awake", 1'b1, sleepIndicator)
      @(posedge core_clk);
      act.cmdMode <= 1'b1;
      wantSleep <= 1'b1;
      cyc(50);
      `CHK("cmd blocks", 1'b1, awake)
      @(posedge core_clk);
      act.cmdMode <= 1'b0;
      act.txPending <= 1'b1;
      cyc(50);
      `CHK("tx blocks", 1'b1, awake)
      @(posedge core_clk);
      act.txPending <= 1'b0;
      waitAwake(1'b0, 50);
      `CHK("drained", 1'b0, awake)
      // Commissioning input wakes from pin sleep
      axiWr(OFF_CTRL, 32'h0000_10F1, r);
      @(posedge core_clk);
      pressBtn <= 1'b1;
      waitAwake(1'b1, 10);
      `CHK("comm wake", 1'b1, awake)
      `CHK("comm button", 1'b1, btnSeen)
      @(posedge core_clk);
      pressBtn <= 1'b0;
      wantAlt <= 1'b1;
      waitAwake(1'b0, 50);
      // Alternate select replaces the request pin
      axiWr(OFF_CTRL, 32'h0000_1151, r);
      @(posedge core_clk);
      wantSleep <= 1'b0;
      cyc(30);
      `CHK("alt holds sleep", 1'b0, awake)
      @(posedge core_clk);
      wantAlt <= 1'b0;
      waitAwake(1'b1, 10);
      `CHK("alt wake", 1'b1, awake)
      // Cyclic sleep with pin wake
      @(posedge core_clk);
      wantSleep <= 1'b1;
      axiWr(OFF_CTRL, 32'h0000_1075, r);
      waitAwake(1'b0, 1000);
      pulseReq();
      `CHK("edge wake", 1'b1, awake)
      cyc(3);
      `CHK("flow ready", 1'b0, flowOut)
      // Three wake units span at least 21 cycles from wake, so look before that
      cyc(15);
      `CHK("short pulse", 1'b1, awake)
      waitAwake(1'b0, 40);
      `CHK("idle sleep", 1'b0, awake)
      @(posedge core_clk);
      wantSleep <= 1'b0;
      cyc(100);
      `CHK("held low", 1'b1, awake)
      @(posedge core_clk);
      wantSleep <= 1'b1;
      waitAwake(1'b0, 50);
      `CHK("rise resumes", 1'b0, awake)
      pulseReq();
      cyc(20);
      `CHK("host may send", 1'b1, hostMaySend)
      @(posedge core_clk);
      act.serRx <= 1'b1;
      @(posedge core_clk);
      act.serRx <= 1'b0;
      cyc(20);
      `CHK("rx extends", 1'b1, awake)
      waitAwake(1'b0, 60);
      `CHK("rx timer ends", 1'b0, awake)
      p0 = pollCnt;
      waitAwake(1'b1, 250);
      cyc(2);
      `CHK("period poll", 1, pollCnt - p0)
      cyc(250);
      `CHK("poll min wake", 1'b1, awake)
      // Synchronous modes
      axiWr(OFF_CTRL, 32'h0000_0078, r);
      cyc(400);
      `CHK("baud 0 no sleep", 1'b1, awake)
      p0 = syncCnt;
      axiWr(OFF_CTRL, 32'h0000_1078, r);
      waitAwake(1'b0, 1000);
      `CHK("asleep ignores", 1'b0, inputAccept)
      waitAwake(1'b1, 300);
      cyc(2);
      `CHK("sync poll", 1'b1, syncCnt > p0)
      @(posedge core_clk);
      sync.netWake <= 16'h0003;
      sync.netSleep <= 16'h0014;
      sync.syncRx <= 1'b1;
      @(posedge core_clk);
      sync.syncRx <= 1'b0;
      axiWr(OFF_CTRL, 32'h0000_1077, r);
      cyc(400);
      `CHK("support awake", 1'b1, awake)
      `CHK("support answer", 1'b1, syncAnswerEn)
      `CHK("net asleep tx", 1'b0, dataTxAllow)
      @(posedge core_clk);
      sync.netAwake <= 1'b1;
      cyc(3);
      `CHK("net awake tx", 1'b1, dataTxAllow)
      closeOut();
   end
endmodule // swc_sleep_ctrl_tb
